// [hdl/cap_sense_params.svh]
// What this block does
// - result_high holds the upper byte of the last finished 16-bit conversion, read only, reset 0.
// - result_low holds the lower byte of the last finished 16-bit conversion, read only, reset 0.
// - scan_mask_low is an 8-bit read/write mask for channels 0 to 7, reset 0.
// - scan_mask_high keeps six writable bits for channels 8 to 13; bits 7:6 read 0, writes ignored.
// - with masking on and at least one mask bit set, the auto-scan visits exactly the channels whose mask bit is 1.
// - with masking off, scan_start_channel gives the first channel put on the mux while auto-scan runs; with masking on it is the lowest masked channel.
// - with auto-scan enabled, a write to scan_start_channel also loads the mux select.
// - with masking off, auto-scan goes back to scan_start_channel after scan_end_channel or after channel 13, whichever comes first; masking on ignores it.
// - bits 7:5 of the start and end registers read 0 and ignore writes.
// - start and end take any code that the mux select takes.
// - threshold_high is read/write, reset 0, the upper byte of the compare threshold.
// - threshold_low is read/write, reset 0, the lower byte of the compare threshold.
// - with masking off, both mask registers play no part in channel choice.
// - polarity 0 flags result above threshold; polarity 1 flags result at or below it.
// - masking on and mode code 111 scans the masked channels over and over.
`ifndef CAP_SENSE_PARAMS_SVH
`define CAP_SENSE_PARAMS_SVH
`define ADDR_SCAN_MASK_LOW   8'hd2
`define ADDR_SCAN_MASK_HIGH  8'hd3
`define ADDR_SCAN_START      8'hdd
`define ADDR_SCAN_END        8'hde
`define ADDR_RESULT_LOW      8'hed
`define ADDR_RESULT_HIGH     8'hee
`define ADDR_THRESHOLD_LOW   8'hfd
`define ADDR_THRESHOLD_HIGH  8'hfe
`define RESET_BYTE           8'h00
`define RESET_RESULT         16'h0000
`define RESET_CHANNEL        5'h00
`define RESET_MASK_HIGH      6'h00
`define MASK_HIGH_PAD        2'h0
`define CHANNEL_PAD          3'h0
`define MODE_AUTO_SCAN       3'h7
`define LAST_SENSE_CHANNEL   5'h0d
`define SENSE_CHANNELS       14
`define CHANNEL_STEP         5'h01
`endif

// [hdl/cap_sense_pkg.sv]
package cap_sense_pkg;
    typedef logic [4:0]  channel_t;
    typedef logic [13:0] mask_t;
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b01,
        SCAN_RUN  = 2'b10
    } scan_state_e;
    typedef struct packed {
        logic [15:0] result;
        logic [7:0]  scan_mask_low;
        logic [5:0]  scan_mask_high;
        channel_t    scan_start_channel;
        channel_t    scan_end_channel;
        logic [7:0]  threshold_low;
        logic [7:0]  threshold_high;
        channel_t    mux_channel_select;
        logic        mux_select_load;
        logic        compare_event;
        logic [7:0]  rdata;
        scan_state_e state;
    } sense_regs_s;
endpackage : cap_sense_pkg

// [hdl/cap_sense_scan_step.sv]
`timescale 1ns/1ps
`include "cap_sense_params.svh"
module cap_sense_scan_step
    import cap_sense_pkg::*;
(
    input  wire cap_sense_pkg::channel_t current,
    input  wire cap_sense_pkg::channel_t scan_start_channel,
    input  wire cap_sense_pkg::channel_t scan_end_channel,
    input  wire cap_sense_pkg::mask_t    scan_mask_bits,
    input  wire logic                    scan_masking_enable,
    output logic [4:0]                   next_channel
);
    import cap_sense_pkg::*;

    function automatic channel_t next_masked(input channel_t cur, input mask_t mask);
        channel_t found;
        channel_t probe;
        logic     hit;
        found = cur;
        probe = cur;
        hit   = 1'b0;
        for (int i = 0; i < `SENSE_CHANNELS; i++) begin
            if (probe >= `LAST_SENSE_CHANNEL) begin
                probe = `RESET_CHANNEL;
            end else begin
                probe = probe + `CHANNEL_STEP;
            end
            if (!hit && mask[probe[3:0]]) begin
                found = probe;
                hit   = 1'b1;
            end
        end
        return found;
    endfunction : next_masked

    always_comb begin
        if (scan_masking_enable) begin
            next_channel = next_masked(current, scan_mask_bits);
        end else if (current == scan_end_channel || current >= `LAST_SENSE_CHANNEL) begin
            next_channel = scan_start_channel;
        end else begin
            next_channel = current + `CHANNEL_STEP;
        end
    end
endmodule : cap_sense_scan_step

// [hdl/cap_sense_result_scan_threshold.sv]
`timescale 1ns/1ps
`include "cap_sense_params.svh"
module cap_sense_result_scan_threshold
    import cap_sense_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_result,
    input  wire logic        scan_masking_enable,
    input  wire logic        comparator_polarity,
    input  wire logic [2:0]  scan_mode,
    input  wire logic        scan_busy,
    output cap_sense_pkg::channel_t mux_channel_select,
    output logic             mux_select_load,
    output cap_sense_pkg::mask_t    scan_mask_bits,
    output logic             compare_event
);
    import cap_sense_pkg::*;

    sense_regs_s regs;
    sense_regs_s next_regs;
    channel_t    step_from;
    channel_t    step_to;
    logic        auto_enabled;
    logic [15:0] threshold;

    function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction : hits

    assign auto_enabled = scan_mode == `MODE_AUTO_SCAN;
    assign threshold    = {regs.threshold_high, regs.threshold_low};

    // idle with masking: search from the last channel so the first set bit wins
    always_comb begin
        if (regs.state == SCAN_IDLE) begin
            step_from = `LAST_SENSE_CHANNEL;
        end else begin
            step_from = regs.mux_channel_select;
        end
    end

    cap_sense_scan_step u_step (
        .current             (step_from),
        .scan_start_channel  (regs.scan_start_channel),
        .scan_end_channel    (regs.scan_end_channel),
        .scan_mask_bits      ({regs.scan_mask_high, regs.scan_mask_low}),
        .scan_masking_enable (scan_masking_enable),
        .next_channel        (step_to)
    );

    always_comb begin
        next_regs                 = regs;
        next_regs.mux_select_load = 1'b0;
        next_regs.compare_event   = 1'b0;

        // both bytes latched in one edge
        if (conv_done) begin
            next_regs.result = conv_result;
            if (!comparator_polarity) begin
                next_regs.compare_event = conv_result > threshold;
            end else begin
                next_regs.compare_event = conv_result <= threshold;
            end
        end

        // scan sequencing
        case (regs.state)
            SCAN_IDLE: begin
                if (auto_enabled && scan_busy) begin
                    next_regs.state           = SCAN_RUN;
                    next_regs.mux_select_load = 1'b1;
                    if (scan_masking_enable) begin
                        next_regs.mux_channel_select = step_to;
                    end else begin
                        next_regs.mux_channel_select = regs.scan_start_channel;
                    end
                end
            end
            SCAN_RUN: begin
                if (!auto_enabled || !scan_busy) begin
                    next_regs.state = SCAN_IDLE;
                end else if (conv_done) begin
                    next_regs.mux_channel_select = step_to;
                    next_regs.mux_select_load    = 1'b1;
                end
            end
            default: begin
                next_regs.state = SCAN_IDLE;
            end
        endcase

        // register writes; a start write overrides a same-cycle scan step
        if (sfr_wr) begin
            if (hits(sfr_addr, `ADDR_SCAN_MASK_LOW)) begin
                next_regs.scan_mask_low = sfr_wdata;
            end
            if (hits(sfr_addr, `ADDR_SCAN_MASK_HIGH)) begin
                next_regs.scan_mask_high = sfr_wdata[5:0];
            end
            if (hits(sfr_addr, `ADDR_SCAN_START)) begin
                next_regs.scan_start_channel = sfr_wdata[4:0];
                if (auto_enabled) begin
                    next_regs.mux_channel_select = sfr_wdata[4:0];
                    next_regs.mux_select_load    = 1'b1;
                end
            end
            if (hits(sfr_addr, `ADDR_SCAN_END)) begin
                next_regs.scan_end_channel = sfr_wdata[4:0];
            end
            if (hits(sfr_addr, `ADDR_THRESHOLD_LOW)) begin
                next_regs.threshold_low = sfr_wdata;
            end
            if (hits(sfr_addr, `ADDR_THRESHOLD_HIGH)) begin
                next_regs.threshold_high = sfr_wdata;
            end
        end

        // reads are registered; unmapped addresses return zero
        if (sfr_rd) begin
            if (hits(sfr_addr, `ADDR_SCAN_MASK_LOW)) begin
                next_regs.rdata = regs.scan_mask_low;
            end else if (hits(sfr_addr, `ADDR_SCAN_MASK_HIGH)) begin
                next_regs.rdata = {`MASK_HIGH_PAD, regs.scan_mask_high};
            end else if (hits(sfr_addr, `ADDR_SCAN_START)) begin
                next_regs.rdata = {`CHANNEL_PAD, regs.scan_start_channel};
            end else if (hits(sfr_addr, `ADDR_SCAN_END)) begin
                next_regs.rdata = {`CHANNEL_PAD, regs.scan_end_channel};
            end else if (hits(sfr_addr, `ADDR_RESULT_LOW)) begin
                next_regs.rdata = regs.result[7:0];
            end else if (hits(sfr_addr, `ADDR_RESULT_HIGH)) begin
                next_regs.rdata = regs.result[15:8];
            end else if (hits(sfr_addr, `ADDR_THRESHOLD_LOW)) begin
                next_regs.rdata = regs.threshold_low;
            end else if (hits(sfr_addr, `ADDR_THRESHOLD_HIGH)) begin
                next_regs.rdata = regs.threshold_high;
            end else begin
                next_regs.rdata = `RESET_BYTE;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            regs.result             <= `RESET_RESULT;
            regs.scan_mask_low      <= `RESET_BYTE;
            regs.scan_mask_high     <= `RESET_MASK_HIGH;
            regs.scan_start_channel <= `RESET_CHANNEL;
            regs.scan_end_channel   <= `RESET_CHANNEL;
            regs.threshold_low      <= `RESET_BYTE;
            regs.threshold_high     <= `RESET_BYTE;
            regs.mux_channel_select <= `RESET_CHANNEL;
            regs.mux_select_load    <= 1'b0;
            regs.compare_event      <= 1'b0;
            regs.rdata              <= `RESET_BYTE;
            regs.state              <= SCAN_IDLE;
        end else begin
            regs <= next_regs;
        end
    end

    assign sfr_rdata          = regs.rdata;
    assign mux_channel_select = regs.mux_channel_select;
    assign mux_select_load    = regs.mux_select_load;
    assign scan_mask_bits     = {regs.scan_mask_high, regs.scan_mask_low};
    assign compare_event      = regs.compare_event;
endmodule : cap_sense_result_scan_threshold

// [test/cap_sense_result_scan_threshold_properties.sv]
`timescale 1ns/1ps
module cap_sense_checker
    import cap_sense_pkg::*;
(
    input wire logic                    clk_sys,
    input wire logic                    sys_rst,
    input wire logic [7:0]              sfr_addr,
    input wire logic                    sfr_wr,
    input wire logic                    sfr_rd,
    input wire logic [7:0]              sfr_wdata,
    input wire logic [7:0]              sfr_rdata,
    input wire logic                    conv_done,
    input wire logic [2:0]              scan_mode,
    input wire cap_sense_pkg::channel_t mux_channel_select,
    input wire logic                    mux_select_load,
    input wire cap_sense_pkg::mask_t    scan_mask_bits,
    input wire logic                    compare_event
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_event_after_done: assert property (compare_event |-> $past(conv_done))
        else $error("compare event without a finished conversion");
    a_mask_low_write: assert property (sfr_wr && sfr_addr == 8'hd2
        |=> scan_mask_bits[7:0] == $past(sfr_wdata)) else $error("low mask not written");
    a_mask_high_write: assert property (sfr_wr && sfr_addr == 8'hd3
        |=> {2'h0, scan_mask_bits[13:8]} == ($past(sfr_wdata) & 8'h3f))
        else $error("high mask not written");
    a_mask_holds: assert property (!sfr_wr |=> $stable(scan_mask_bits))
        else $error("mask changed without a write");
    a_start_loads_mux: assert property (sfr_wr && sfr_addr == 8'hdd && scan_mode == 3'h7
        |=> mux_select_load && {3'h0, mux_channel_select} == ($past(sfr_wdata) & 8'h1f))
        else $error("start write did not load mux");
    a_load_needs_auto: assert property (mux_select_load |-> $past(scan_mode) == 3'h7)
        else $error("mux load outside auto scan");
    a_mux_holds: assert property (!mux_select_load |-> $stable(mux_channel_select))
        else $error("mux changed without load");
    a_chan_pad_read: assert property (sfr_rd && sfr_addr inside {8'hdd, 8'hde}
        |=> sfr_rdata[7:5] == 3'h0) else $error("channel pad bits not zero");
    a_mask_low_read: assert property (sfr_rd && sfr_addr == 8'hd2
        |=> {6'h0, sfr_rdata} == ($past(scan_mask_bits) & 14'h00ff))
        else $error("low mask read wrong");
    a_mask_high_read: assert property (sfr_rd && sfr_addr == 8'hd3
        |=> sfr_rdata == 8'($past(scan_mask_bits) >> 8)) else $error("high mask read wrong");
endmodule : cap_sense_checker

// [test/cap_sense_result_scan_threshold_tb.sv]
`timescale 1ns/1ps
bind cap_sense_result_scan_threshold cap_sense_checker chk_u (.clk_sys, .sys_rst, .sfr_addr,
    .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .conv_done, .scan_mode, .mux_channel_select,
    .mux_select_load, .scan_mask_bits, .compare_event);
module cap_sense_result_scan_threshold_tb;
    import cap_sense_pkg::*;
    logic        clk_sys, sys_rst, sfr_wr, sfr_rd, conv_done, scan_masking_enable, rd_q;
    logic        comparator_polarity, scan_busy, mux_select_load, compare_event, done_q;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
    logic [15:0] conv_result, thr, res;
    logic [2:0]  scan_mode;
    channel_t    mux_channel_select;
    mask_t       scan_mask_bits;
    logic [7:0]  exp_byte[$];
    logic        exp_flag[$];
    channel_t    exp_chan[$];
    logic [7:0]  addrs[9] = '{8'hd2, 8'hd3, 8'hdd, 8'hde, 8'hed, 8'hee, 8'hfd, 8'hfe, 8'h00};
    logic [7:0]  keep[9] = '{8'hff, 8'h3f, 8'h1f, 8'h1f, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
    channel_t    seq[6] = '{5'h04, 5'h05, 5'h03, 5'h02, 5'h0d, 5'h00};
    logic [31:0] seed = 32'hc91e90ed;
    int          n_mismatch = 0, tests_run = 0, cycles = 0;
    cap_sense_result_scan_threshold dut_u (.clk_sys, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd,
        .sfr_wdata, .sfr_rdata, .conv_done, .conv_result, .scan_masking_enable,
        .comparator_polarity, .scan_mode, .scan_busy, .mux_channel_select, .mux_select_load,
        .scan_mask_bits, .compare_event);
    initial begin
        clk_sys = 0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr
    task automatic cyc(input logic w, r, d, input logic [7:0] a, v, input logic [15:0] c);
        @(negedge clk_sys);
        sfr_wr = w;
        sfr_rd = r;
        conv_done = d;
        sfr_addr = a;
        sfr_wdata = v;
        conv_result = c;
    endtask : cyc
    task automatic wr(input logic [7:0] a, v);
        cyc(1, 0, 0, a, v, 16'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, e);
        exp_byte.push_back(e);
        cyc(0, 1, 0, a, 8'h0, 16'h0);
    endtask : rd
    task automatic conv(input logic [15:0] c);
        exp_flag.push_back(comparator_polarity ? c <= thr : c > thr);
        cyc(0, 0, 1, 8'h0, 8'h0, c);
    endtask : conv
    task automatic chk(input string n, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic chk_byte(input logic [7:0] e);
        chk("sfr_rdata", {8'h0, e}, {8'h0, sfr_rdata});
    endtask : chk_byte
    task automatic chk_flag(input logic e);
        chk("compare_event", {15'h0, e}, {15'h0, compare_event});
    endtask : chk_flag
    task automatic chk_chan(input channel_t e);
        chk("mux_channel_select", {11'h0, e}, {11'h0, mux_channel_select});
    endtask : chk_chan
    task automatic chk_mask(input mask_t e);
        chk("scan_mask_bits", {2'h0, e}, {2'h0, scan_mask_bits});
    endtask : chk_mask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    always @(posedge clk_sys) begin
        rd_q <= sfr_rd;
        done_q <= conv_done;
        cycles <= cycles + 1;
    end
    always @(negedge clk_sys) begin
        if (rd_q) chk_byte(exp_byte.pop_front());
        if (done_q || compare_event) chk_flag(done_q ? exp_flag.pop_front() : 1'b0);
        if (mux_select_load) begin
            chk_chan(exp_chan.size() > 0 ? exp_chan.pop_front() : 5'h1f);
        end
        if (cycles > 2000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        {sfr_wr, sfr_rd, conv_done, scan_masking_enable, comparator_polarity, scan_busy} = '0;
        {sfr_addr, sfr_wdata, conv_result, scan_mode, thr} = '0;
        sys_rst = 1;
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys) sys_rst = 0;
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        $display("reset values done");
        foreach (addrs[i]) begin
            seed = lfsr(seed);
            wr(addrs[i], seed[7:0]);
            rd(addrs[i], seed[7:0] & keep[i]);
        end
        $display("register access done");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            comparator_polarity = i[0];
            thr = seed[31:16];
            res = (i < 4) ? thr + 16'(i[1]) : seed[15:0];
            wr(8'hfd, thr[7:0]);
            wr(8'hfe, thr[15:8]);
            conv(res);
            rd(8'hed, res[7:0]);
            rd(8'hee, res[15:8]);
        end
        conv(16'h0001);
        conv(16'hfffe);
        rd(8'hed, 8'hfe);
        rd(8'hee, 8'hff);
        $display("conversion results done");
        wr(8'hd2, 8'h05);
        wr(8'hd3, 8'h20);
        scan_mode = 3'h7;
        exp_chan.push_back(5'h03);
        wr(8'hdd, 8'h03);
        chk_mask(14'h2005);
        wr(8'hde, 8'h05);
        scan_busy = 1;
        exp_chan.push_back(5'h03);
        for (int i = 0; i < 6; i++) begin
            if (i == 3) begin
                cyc(0, 0, 0, 8'h0, 8'h0, 16'h0);
                scan_busy = 0;
                cyc(0, 0, 0, 8'h0, 8'h0, 16'h0);
                scan_masking_enable = 1;
                scan_busy = 1;
                exp_chan.push_back(5'h00);
            end
            exp_chan.push_back(seq[i]);
            conv(16'h0);
        end
        repeat (3) cyc(0, 0, 0, 8'h0, 8'h0, 16'h0);
        $display("auto scan done");
        chk("pending results", 16'h0, 16'(exp_byte.size() + exp_flag.size() + exp_chan.size()));
        give_verdict();
    end
endmodule : cap_sense_result_scan_threshold_tb
